// File: src/ssp_params.svh
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses)
// ---------------------------------------------------------------
`define SSP_OFF_MISC1_A 12'h000
`define SSP_OFF_MISC1_B 12'h004
`define SSP_OFF_MISC2 12'h008
`define SSP_OFF_STATUS 12'h00c

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SSP_MISC1_SPK_BIT 4
`define SSP_MISC2_DMA_BIT 6
`define SSP_MISC2_BYPASS_BIT 0
`define SSP_STAT_VPP_BIT 0
`define SSP_STAT_TC_BIT 1
`define SSP_STAT_BASE_LSB 4
`define SSP_STAT_CLKSEL_BIT 8

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SSP_MISC1_RST 8'h00
`define SSP_MISC2_RST 8'h00

`endif

// File: src/ssp_pkg.sv
package ssp_pkg;
   typedef enum logic {
      SSP_CLK_SYNTH,
      SSP_CLK_DIRECT
   } ssp_clksel_e;
endpackage : ssp_pkg

// File: src/ssp_strap_speaker.sv
// Operation
// - Pin low at power-good rise numbers sockets 2 and 3.
// - Pin high at power-good rise numbers sockets 0 and 1.
// - Pin pulled up during reset, giving default numbering from zero.
// - After reset pin floats; driven only when a speaker route enable is set.
// - Speaker output is inverted XOR of enabled sockets' card audio inputs.
// - Socket timing clock derived from 14.318 MHz input via synthesizer.
// - Direct 25 MHz input may be used, bypassing the synthesizer.
// - Outside DMA mode, supply-valid input is readable status.
// - In DMA mode, supply-valid input is terminal count, active high.
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "ssp_params.svh"

module ssp_strap_speaker #(
   parameter int NUM_SOCKETS = 2
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Power good and strap pin
   input wire logic power_good_in,
   input wire logic speaker_or_config_pin_i,
   output logic speaker_or_config_pin_o,
   output logic speaker_or_config_pin_oe,
   output logic config_pullup_en,
   // Card audio inputs
   input wire logic [NUM_SOCKETS-1:0] card_audio_in,
   // Supply valid / terminal count
   input wire logic vpp_valid_n_in,
   output logic dma_tc,
   // Clock source select and socket numbering
   output ssp_pkg::ssp_clksel_e timing_clk_sel,
   output logic [1:0] socket_base
);

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (NUM_SOCKETS < 1 || NUM_SOCKETS > 2) begin : g_bad_sockets
      $error("NUM_SOCKETS must be 1 or 2");
   end

   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [2:0] pg_s1_q;
   logic [2:0] pg_s1_d;
   logic [2:0] pg_s2_q;
   logic [2:0] pg_s2_d;
   logic pg_prev_q;
   logic pg_prev_d;

   always_comb begin
      pg_s1_d = {vpp_valid_n_in, speaker_or_config_pin_i, power_good_in};
      pg_s2_d = pg_s1_q;
      pg_prev_d = pg_s2_q[0];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_s1_q <= 3'h0;
         pg_s2_q <= 3'h0;
         pg_prev_q <= 1'b0;
      end else begin
         pg_s1_q <= pg_s1_d;
         pg_s2_q <= pg_s2_d;
         pg_prev_q <= pg_prev_d;
      end
   end

   logic [NUM_SOCKETS-1:0] aud_s1_q;
   logic [NUM_SOCKETS-1:0] aud_s1_d;
   logic [NUM_SOCKETS-1:0] aud_s2_q;
   logic [NUM_SOCKETS-1:0] aud_s2_d;

   always_comb begin
      aud_s1_d = card_audio_in;
      aud_s2_d = aud_s1_q;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         aud_s1_q <= '0;
         aud_s2_q <= '0;
      end else begin
         aud_s1_q <= aud_s1_d;
         aud_s2_q <= aud_s2_d;
      end
   end

   logic pg_sync;
   logic pin_sync;
   logic vpp_sync;
   logic pg_rise;
   assign pg_sync = pg_s2_q[0];
   assign pin_sync = pg_s2_q[1];
   assign vpp_sync = pg_s2_q[2];
   assign pg_rise = pg_sync & ~pg_prev_q;

   // ---------------------------------------------------------------
   // Strap capture
   // ---------------------------------------------------------------
   logic base_hi_q;
   logic base_hi_d;

   always_comb begin
      base_hi_d = base_hi_q;
      if (pg_rise) begin
         base_hi_d = ~pin_sync;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         base_hi_q <= 1'b0;
      end else begin
         base_hi_q <= base_hi_d;
      end
   end

   assign socket_base = base_hi_q ? 2'h2 : 2'h0;
   assign config_pullup_en = ~pg_sync;

   // ---------------------------------------------------------------
   // Bus handshake and decode
   // ---------------------------------------------------------------
   logic [7:0] misc1_q [NUM_SOCKETS];
   logic [7:0] misc1_d [NUM_SOCKETS];
   logic [7:0] misc2_q;
   logic [7:0] misc2_d;
   logic [NUM_SOCKETS-1:0] misc1_hit;
   logic [NUM_SOCKETS-1:0] spk_en;
   logic misc2_hit;
   logic wr_en;
   logic rd_setup;
   logic addr_ok;

   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable;
   assign pready = 1'b1;
   assign misc2_hit = (paddr == `SSP_OFF_MISC2);

   always_comb begin
      addr_ok = 1'b0;
      unique case (paddr)
         `SSP_OFF_MISC1_A: addr_ok = 1'b1;
         `SSP_OFF_MISC1_B: addr_ok = (NUM_SOCKETS > 1);
         `SSP_OFF_MISC2: addr_ok = 1'b1;
         `SSP_OFF_STATUS: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~addr_ok;

   // ---------------------------------------------------------------
   // Control registers
   // ---------------------------------------------------------------
   always_comb begin
      misc2_d = misc2_q;
      if (wr_en && misc2_hit) begin
         misc2_d = pwdata[7:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_SOCKETS; gi++) begin : g_sock
         assign misc1_hit[gi] = (paddr == 12'(`SSP_OFF_MISC1_A + 4 * gi));
         assign spk_en[gi] = misc1_q[gi][`SSP_MISC1_SPK_BIT];

         always_comb begin
            misc1_d[gi] = misc1_q[gi];
            if (wr_en && misc1_hit[gi]) begin
               misc1_d[gi] = pwdata[7:0];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               misc1_q[gi] <= `SSP_MISC1_RST;
            end else begin
               misc1_q[gi] <= misc1_d[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         misc2_q <= `SSP_MISC2_RST;
      end else begin
         misc2_q <= misc2_d;
      end
   end

   // ---------------------------------------------------------------
   // Speaker output
   // ---------------------------------------------------------------
   logic spk_q;
   logic spk_d;
   logic spk_oe_q;
   logic spk_oe_d;

   always_comb begin
      spk_oe_d = pg_sync & (|spk_en);
      spk_d = ~(^(aud_s2_q & spk_en));
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spk_q <= 1'b1;
         spk_oe_q <= 1'b0;
      end else begin
         spk_q <= spk_d;
         spk_oe_q <= spk_oe_d;
      end
   end

   // ---------------------------------------------------------------
   // Pin drive
   // ---------------------------------------------------------------
   assign speaker_or_config_pin_o = spk_q;
   assign speaker_or_config_pin_oe = spk_oe_q;

   // ---------------------------------------------------------------
   // Clock source select
   // ---------------------------------------------------------------
   assign timing_clk_sel = misc2_q[`SSP_MISC2_BYPASS_BIT] ?
                           ssp_pkg::SSP_CLK_DIRECT :
                           ssp_pkg::SSP_CLK_SYNTH;

   // ---------------------------------------------------------------
   // Supply-valid / terminal count
   // ---------------------------------------------------------------
   logic dma_mode;
   logic tc_q;
   logic tc_d;

   assign dma_mode = misc2_q[`SSP_MISC2_DMA_BIT];

   always_comb begin
      tc_d = dma_mode & vpp_sync;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tc_q <= 1'b0;
      end else begin
         tc_q <= tc_d;
      end
   end

   assign dma_tc = tc_q;

   // ---------------------------------------------------------------
   // Read data
   // ---------------------------------------------------------------
   logic [31:0] rd_d;
   logic [31:0] rd_q;

   always_comb begin
      rd_d = 32'h0;
      unique case (paddr)
         `SSP_OFF_MISC1_A: begin
            rd_d[7:0] = misc1_q[0];
         end
         `SSP_OFF_MISC1_B: begin
            if (NUM_SOCKETS > 1) begin
               rd_d[7:0] = misc1_q[NUM_SOCKETS-1];
            end
         end
         `SSP_OFF_MISC2: begin
            rd_d[7:0] = misc2_q;
         end
         `SSP_OFF_STATUS: begin
            rd_d[`SSP_STAT_VPP_BIT] = ~dma_mode & ~vpp_sync;
            rd_d[`SSP_STAT_TC_BIT] = dma_tc;
            rd_d[`SSP_STAT_BASE_LSB +: 2] = socket_base;
            rd_d[`SSP_STAT_CLKSEL_BIT] = (timing_clk_sel == ssp_pkg::SSP_CLK_DIRECT);
         end
         default: rd_d = 32'h0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_q <= 32'h0;
      end else if (rd_setup) begin
         rd_q <= rd_d;
      end
   end

   assign prdata = rd_q;

endmodule : ssp_strap_speaker

// File: bench/ssp_chk_assertions.sv
`timescale 1ns/1ps
module ssp_chk #(
   parameter int NUM_SOCKETS = 2
) (
   // Bus
   input wire logic pclk, presetn, psel, penable, pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   // Pins
   input wire logic power_good_in, speaker_or_config_pin_i, speaker_or_config_pin_o,
   input wire logic speaker_or_config_pin_oe, config_pullup_en, vpp_valid_n_in, dma_tc,
   input wire logic [NUM_SOCKETS-1:0] card_audio_in,
   input wire ssp_pkg::ssp_clksel_e timing_clk_sel,
   input wire logic [1:0] socket_base
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_pu; !power_good_in [*3] |-> config_pullup_en; endproperty
   a_pu: assert property (p_pu) else $error("pull-up off while power low");
   property p_float; config_pullup_en [*3] |-> !speaker_or_config_pin_oe; endproperty
   a_float: assert property (p_float) else $error("pin driven during reset");
   sequence s_low; ($rose(power_good_in) && !speaker_or_config_pin_i) ##1
      !speaker_or_config_pin_i [*5]; endsequence
   property p_base2; s_low |-> ##[0:2] socket_base == 2'h2; endproperty
   a_base2: assert property (p_base2) else $error("low strap not numbered 2");
   property p_base0; ($rose(power_good_in) && speaker_or_config_pin_i) ##1
      speaker_or_config_pin_i [*5] |-> ##[0:2] socket_base == 2'h0; endproperty
   a_base0: assert property (p_base0) else $error("high strap not numbered 0");
   property p_hold; power_good_in [*8] |-> $stable(socket_base); endproperty
   a_hold: assert property (p_hold) else $error("numbering changed");
   property p_tc; !vpp_valid_n_in [*4] |-> !dma_tc; endproperty
   a_tc: assert property (p_tc) else $error("count high with input low");
   property p_spk; (card_audio_in == '0) [*5] |-> speaker_or_config_pin_o; endproperty
   a_spk: assert property (p_spk) else $error("speaker low with quiet cards");
   property p_stat; psel && penable && !pwrite && paddr == 12'h00c |->
      prdata[5:4] == socket_base && prdata[8] == timing_clk_sel && prdata[1] == dma_tc;
   endproperty
   a_stat: assert property (p_stat) else $error("status mismatch");
   c_oe: cover property ($rose(speaker_or_config_pin_oe));
   c_b2: cover property (socket_base == 2'h2);
   c_tc: cover property (dma_tc);
endmodule : ssp_chk

bind ssp_strap_speaker ssp_chk #(.NUM_SOCKETS(NUM_SOCKETS)) i_ssp_chk (.pclk, .presetn,
   .psel, .penable, .pwrite, .paddr, .prdata, .power_good_in, .speaker_or_config_pin_i,
   .speaker_or_config_pin_o, .speaker_or_config_pin_oe, .config_pullup_en,
   .vpp_valid_n_in, .dma_tc, .card_audio_in, .timing_clk_sel, .socket_base);

// File: bench/ssp_far.sv
`timescale 1ns/1ps
module ssp_far (
   // Pin parties
   input wire logic pin_o, pin_oe, pull_up, strap_en, strap_lvl,
   // Wire level
   output logic pin_lvl
);
   logic flt = 1'h0;
   // A released pin keeps changing
   initial forever #100 flt = ~flt;
   assign pin_lvl = pin_oe ? pin_o : strap_en ? strap_lvl : pull_up ? 1'h1 : flt;
endmodule : ssp_far

// File: bench/socket_strap_and_speaker_out_bench.sv
`timescale 1ns/1ps
module socket_strap_and_speaker_out_bench;
   logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic power_good_in = 1'h0, vpp_valid_n_in = 1'h1, strap_en = 1'h0, strap_lvl = 1'h0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata, lfsr = 32'h2225;
   logic [1:0] card_audio_in = 2'h0, socket_base;
   logic pready, pslverr, speaker_or_config_pin_i, speaker_or_config_pin_o;
   logic speaker_or_config_pin_oe, config_pullup_en, dma_tc;
   ssp_pkg::ssp_clksel_e timing_clk_sel;
   logic [32:0] expq[$];
   int failures = 0, cmp_count = 0;
   ssp_strap_speaker i_ssp_strap_speaker (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .power_good_in, .speaker_or_config_pin_i,
      .speaker_or_config_pin_o, .speaker_or_config_pin_oe, .config_pullup_en,
      .card_audio_in, .vpp_valid_n_in, .dma_tc, .timing_clk_sel, .socket_base);
   ssp_far i_ssp_far (.pin_o(speaker_or_config_pin_o), .pin_oe(speaker_or_config_pin_oe),
      .pull_up(config_pullup_en), .strap_en, .strap_lvl, .pin_lvl(speaker_or_config_pin_i));
   initial forever #50 pclk = ~pclk;
   task automatic chk(input logic [32:0] got, input logic [32:0] want);
      cmp_count++;
      if (got !== want) begin
         failures++;
         $display("Error at %0t: got %h want %h", $time, got, want);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) expq.push_back(e);
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   task automatic boot(input logic en, input logic lv);
      power_good_in <= 1'h0;
      strap_en <= en;
      strap_lvl <= lv;
      repeat (6) @(posedge pclk);
      power_good_in <= 1'h1;
      repeat (9) @(posedge pclk);
      strap_en <= 1'h0;
   endtask : boot
   function automatic logic [32:0] st(input logic [1:0] b, input logic c, t, v);
      return {24'h0, c, 2'h0, b, 2'h0, t, v};
   endfunction : st
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_step
   // Read results
   always @(posedge pclk) if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, expq.pop_front());
   initial begin
      #400000;
      failures++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      boot(1'h0, 1'h0);
      apb(1'h0, 12'h00c, 32'h0, st(2'h0, 1'h0, 1'h0, 1'h0));
      boot(1'h1, 1'h0);
      repeat (20) @(posedge pclk);
      apb(1'h0, 12'h00c, 32'h0, st(2'h2, 1'h0, 1'h0, 1'h0));
      boot(1'h1, 1'h1);
      apb(1'h0, 12'h00c, 32'h0, st(2'h0, 1'h0, 1'h0, 1'h0));
      apb(1'h0, 12'h010, 32'h0, {1'h1, 32'h0});
      for (int i = 0; i < 8; i++) begin
         vpp_valid_n_in <= i[2];
         apb(1'h1, 12'h008, {25'h0, i[1], 5'h0, i[0]}, 33'h0);
         apb(1'h0, 12'h008, 32'h0, {26'h0, i[1], 5'h0, i[0]});
         apb(1'h0, 12'h00c, 32'h0, st(2'h0, i[0], i[1] & i[2], !i[1] & !i[2]));
      end
      chk({32'h0, speaker_or_config_pin_oe}, 33'h0);
      apb(1'h1, 12'h000, 32'h10, 33'h0);
      apb(1'h0, 12'h000, 32'h0, 33'h10);
      for (int k = 0; k < 20; k++) begin
         if (k == 10) begin
            apb(1'h1, 12'h004, 32'h10, 33'h0);
            apb(1'h0, 12'h004, 32'h0, 33'h10);
         end
         lfsr = lfsr_step(lfsr);
         card_audio_in <= lfsr[1:0];
         repeat (4) @(posedge pclk);
         chk({31'h0, speaker_or_config_pin_oe, speaker_or_config_pin_o},
             {32'h1, k < 10 ? ~lfsr[0] : ~^lfsr[1:0]});
      end
      close_out();
   end
endmodule : socket_strap_and_speaker_out_bench
